// [rtl/mmc_pkg.sv]
package mmc_pkg;
  // Clock rate and timing limits in their own units
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned T_MASK_MS = 100;
  localparam int unsigned T_SEL_US = 100;
  localparam int unsigned T_PDON_MS = 100;
  localparam int unsigned T_PDOFF_MS = 300;
  localparam int unsigned T_IRQOFF_US = 500;
  // Derived cycle counts, exact products of clock rate and time
  localparam int unsigned MASK_CYC = T_MASK_MS * 1000 * CLK_MHZ;
  localparam int unsigned SEL_CYC = T_SEL_US * CLK_MHZ;
  localparam int unsigned PDON_CYC = T_PDON_MS * 1000 * CLK_MHZ;
  localparam int unsigned PDOFF_CYC = T_PDOFF_MS * 1000 * CLK_MHZ;
  localparam int unsigned IRQOFF_CYC = T_IRQOFF_US * CLK_MHZ;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  // Field layout
  localparam int unsigned STAT_W = 5;
  localparam int unsigned COND_W = 4;
  localparam int unsigned READY_BIT = 0;
  localparam int unsigned COND_LSB = 1;
  localparam int unsigned PDOWN_BIT = 0;
  localparam int unsigned WAKE_W = 24;
  // Reset values
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [4:0] MASK_RST = 5'h1f;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // Power and select state as software sees it
  typedef struct packed {
    logic selected;
    logic lp_pin;
    logic low_power;
    logic not_ready;
  } mmc_state_t;
  localparam mmc_state_t STATE_RST = 4'b0011;
endpackage : mmc_pkg

// [rtl/mmc_top.sv]
// Operation
// RULE1 - Cleared mask resumes interrupt within 100 ms
// RULE2 - Select asserted: answer bus within 100 us
// RULE3 - Select released: stop answering within 100 us
// RULE4 - Power-down bit set: low power within 100 ms
// RULE5 - Power-down cleared: fully functional within 300 ms
// RULE6 - Functional means not-ready cleared, interrupt raised
// RULE7 - Write limits start at write completion
// RULE8 - Read limits start at read completion
// RULE9 - Flag cleared: interrupt released within 500 us
// RULE10 - Mask set: condition stops interrupt within 100 ms
// RULE11 - Select and interrupt pins are active low
module mmc_top import mmc_pkg::*; #(
  parameter int unsigned WAKE_CYC = PDOFF_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic module_select_n_i,
  input wire logic module_reset_n_i,
  input wire logic low_power_pin_i,
  input wire logic [COND_W-1:0] cond_i,
  output logic service_request_n_o,
  output logic irq_o,
  output logic bus_active_o,
  output logic low_power_o,
  output logic module_present_n_o
);

  logic [2:0] sel_sync;
  logic [2:0] rst_sync;
  logic [2:0] lp_sync;
  logic sel_q;
  logic mrst_q;
  logic lp_q;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic pdown;
  logic not_ready;
  logic [WAKE_W-1:0] wake_cnt;
  logic [STAT_W-1:0] next_status;
  logic [31:0] next_rdata;

  // Three-stage pin synchronisers; a change counts once stages two and three agree
  // The first stage may go metastable, so only stages two and three are compared
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sel_sync <= 3'h7;
      rst_sync <= 3'h7;
      lp_sync <= 3'h0;
      sel_q <= 1'b0;
      mrst_q <= 1'b0;
      lp_q <= 1'b0;
    end else begin
      sel_sync <= {sel_sync[1:0], module_select_n_i};
      rst_sync <= {rst_sync[1:0], module_reset_n_i};
      lp_sync <= {lp_sync[1:0], low_power_pin_i};
      if (sel_sync[1] == sel_sync[2]) sel_q <= ~sel_sync[2]; // see RULE2 see RULE3 see RULE11
      if (rst_sync[1] == rst_sync[2]) mrst_q <= ~rst_sync[2];
      if (lp_sync[1] == lp_sync[2]) lp_q <= lp_sync[2];
    end
  end

  // Bus decode; one wait state so every bus output comes from a flop
  // Trade-off: one extra cycle per transfer buys short paths into the read mux
  wire acc = psel_i && penable_i;
  wire done = acc && pready_o;
  wire hit_status = (paddr_i == OFS_STATUS);
  wire hit_mask = (paddr_i == OFS_MASK);
  wire hit_ctrl = (paddr_i == OFS_CTRL);
  wire hit_state = (paddr_i == OFS_STATE);
  wire mapped = hit_status || hit_mask || hit_ctrl || hit_state;
  // Deselected module still answers the bus, but refuses every transfer with an error
  wire refuse = !mapped || !sel_q; // see RULE2 see RULE3
  wire wr_ok = done && pwrite_i && !pslverr_o; // see RULE7
  wire rd_ok = done && !pwrite_i && !pslverr_o; // see RULE8
  wire wr_status = wr_ok && hit_status;
  wire wr_mask = wr_ok && hit_mask;
  wire wr_ctrl = wr_ok && hit_ctrl;

  // Read mux, prepared during the first access cycle
  // Unmapped addresses read as zero; the error flag tells software why
  mmc_state_t st;
  assign st = '{selected: sel_q, lp_pin: lp_q, low_power: low_power_o, not_ready: not_ready};
  assign next_rdata = hit_status ? {{(32-STAT_W){1'b0}}, status} :
                      hit_mask ? {{(32-STAT_W){1'b0}}, mask} :
                      hit_ctrl ? {31'h0000_0000, pdown} :
                      hit_state ? {28'h000_0000, st} : RDATA_RST;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= RDATA_RST;
    end else begin
      pready_o <= acc && !pready_o;
      pslverr_o <= acc && !pready_o && refuse;
      prdata_o <= (acc && !pready_o && !refuse && !pwrite_i) ? next_rdata : RDATA_RST;
    end
  end

  // Wake sequence: not-ready held in power-down or soft reset, then counted out
  // Both causes share the hold path, so either one restarts the full wake count
  wire hold = pdown || mrst_q;
  wire wake_end = (wake_cnt == WAKE_W'(WAKE_CYC - 1));
  wire ready_evt = not_ready && !hold && wake_end; // see RULE6
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pdown <= CTRL_RST;
      not_ready <= 1'b1;
      wake_cnt <= '0;
    end else begin
      if (wr_ctrl) pdown <= pwdata_i[PDOWN_BIT]; // see RULE4 see RULE5
      if (hold) begin
        not_ready <= 1'b1;
        wake_cnt <= '0;
      end else if (ready_evt) begin
        not_ready <= 1'b0; // see RULE5
        wake_cnt <= '0;
      end else if (not_ready) begin
        wake_cnt <= wake_cnt + 1'b1;
      end
    end
  end

  // Sticky flags: a new event wins over a write-one clear in the same cycle
  // A lost event is worse than a repeated interrupt, hence set over clear
  wire [STAT_W-1:0] set_vec = {cond_i, ready_evt};
  wire [STAT_W-1:0] clr_vec = wr_status ? pwdata_i[STAT_W-1:0] : '0;
  assign next_status = (status & ~clr_vec) | set_vec;
  wire pend = |(next_status & ~mask);
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      status <= STATUS_RST;
      mask <= MASK_RST;
      irq_o <= 1'b0;
      service_request_n_o <= 1'b1;
      low_power_o <= 1'b1;
      bus_active_o <= 1'b0;
      module_present_n_o <= 1'b0;
    end else begin
      status <= next_status; // see RULE9
      if (wr_mask) mask <= pwdata_i[STAT_W-1:0]; // see RULE1 see RULE10
      // Mask change reaches irq_o on the second edge after the write, far inside the allowed time
      irq_o <= pend; // see RULE1 see RULE9 see RULE10
      service_request_n_o <= ~pend; // see RULE11
      low_power_o <= hold || lp_q || (wr_ctrl && pwdata_i[PDOWN_BIT]); // see RULE4
      bus_active_o <= sel_q;
      module_present_n_o <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_sel_on: assert property (module_select_n_i == 1'b0 [*6] |=> bus_active_o) // see RULE2
    else $error("Select held low but bus not active");
  a_sel_off: assert property (module_select_n_i [*6] |=> !bus_active_o) // see RULE3
    else $error("Select released but bus still active");
  a_off_refuse: assert property (module_select_n_i [*5] ##1 acc && !pready_o |=> pslverr_o) // see RULE3
    else $error("Deselected module answered a transfer");
  a_pdown_low: assert property (wr_ctrl && pwdata_i[PDOWN_BIT] |=> low_power_o [*2]) // see RULE4
    else $error("Power-down write did not lower power");
  a_wake_bound: assert property (not_ready && !hold |-> wake_cnt < WAKE_W'(WAKE_CYC)) // see RULE5
    else $error("Wake count passed its limit");
  a_ready_flag: assert property (not_ready && !hold && wake_end |=> !not_ready && status[READY_BIT]) // see RULE6
    else $error("Ready event did not set its flag");
  a_ready_irq: assert property ($fell(not_ready) && !mask[READY_BIT] |=> irq_o) // see RULE6
    else $error("Ready event raised no interrupt");
  a_mask_stop: assert property (wr_mask && pwdata_i[STAT_W-1:0] == 5'h1f |=> ##1 !irq_o) // see RULE10
    else $error("Fully masked flags still interrupt");
  a_mask_resume: assert property (wr_mask && |(status & ~pwdata_i[STAT_W-1:0]) |=> ##1 irq_o) // see RULE1
    else $error("Unmasked flag did not interrupt");
  a_clear_rel: assert property (wr_status && pwdata_i[STAT_W-1:0] == 5'h1f && !ready_evt && cond_i == '0
    ##1 cond_i == '0 && !ready_evt |=> !irq_o) // see RULE9
    else $error("Interrupt not released after clear");
  a_pin_pair: assert property (service_request_n_o == !irq_o) // see RULE11
    else $error("Interrupt pin disagrees with level");

  // Bus handshake shape: one wait state, error only with ready, quiet data otherwise
  a_rdy_wait: assert property (acc && !pready_o |=> pready_o) // see RULE2
    else $error("Access cycle got no ready");

  a_rdy_pulse: assert property (pready_o |=> !pready_o)
    else $error("Ready stood longer than one cycle");

  a_idle_noack: assert property (!psel_i |=> !pready_o)
    else $error("Ready without a request");

  a_idle_noerr: assert property (!acc |=> !pslverr_o) // see RULE3
    else $error("Error flag without an access");

  a_err_with_rdy: assert property (pslverr_o |-> pready_o) // see RULE3
    else $error("Error flag without ready");

  a_mapped_ok: assert property (acc && !pready_o && !refuse |=> !pslverr_o) // see RULE2
    else $error("Selected module refused a mapped transfer");

  a_rdata_quiet: assert property (!pready_o |-> prdata_o == RDATA_RST)
    else $error("Read data outside the ready cycle");

  a_rd_mask: assert property (rd_ok && hit_mask // see RULE10
    |-> prdata_o == {{(32-STAT_W){1'b0}}, mask})
    else $error("Mask read returned wrong word");

  // A refused transfer must leave every register alone
  a_refuse_keep: assert property (done && pslverr_o && pwrite_i // see RULE3
    |=> $stable(mask) && $stable(pdown))
    else $error("Refused write changed a register");

  // Register stores
  a_mask_set: assert property (wr_mask && pwdata_i[READY_BIT] |=> mask[READY_BIT]) // see RULE10
    else $error("Mask bit not set by write");

  a_mask_clr: assert property (wr_mask && !pwdata_i[READY_BIT] |=> !mask[READY_BIT]) // see RULE1
    else $error("Mask bit not cleared by write");

  a_ctrl_set: assert property (wr_ctrl && pwdata_i[PDOWN_BIT] |=> pdown) // see RULE4
    else $error("Power-down bit not set by write");

  a_ctrl_clr: assert property (wr_ctrl && !pwdata_i[PDOWN_BIT] |=> !pdown) // see RULE5
    else $error("Power-down bit not cleared by write");

  // Select path: internal select only moves when the last two stages agree
  a_sync_agree: assert property (sel_sync[1] != sel_sync[2] |=> $stable(sel_q)) // see RULE2
    else $error("Select moved on a disagreeing sample");

  a_act_follow: assert property (rst_n_i |=> bus_active_o == $past(sel_q)) // see RULE3
    else $error("Bus active lags internal select");

  // Power path: pin, bit and soft reset all hold low power
  a_pin_lowpwr: assert property (lp_q |=> low_power_o) // see RULE4
    else $error("Low power pin did not lower power");

  a_pdown_hold: assert property (pdown |=> not_ready) // see RULE4
    else $error("Power-down left the module ready");

  a_soft_rst: assert property (mrst_q |=> not_ready)
    else $error("Soft reset left the module ready");

  a_lp_release: assert property (!hold && !lp_q && !(wr_ctrl && pwdata_i[PDOWN_BIT]) // see RULE5
    |=> !low_power_o)
    else $error("Low power kept with no cause");

  // Wake counter
  a_wake_step: assert property (rst_n_i && not_ready && !hold && !wake_end // see RULE5
    |=> wake_cnt == $past(wake_cnt) + 1'b1)
    else $error("Wake count skipped a step");

  a_wake_reset: assert property (hold |=> wake_cnt == '0) // see RULE4
    else $error("Wake count not restarted by hold");

  a_ready_once: assert property (ready_evt |=> !ready_evt) // see RULE6
    else $error("Ready event repeated");

  a_ready_stays: assert property (!not_ready && !hold |=> !not_ready) // see RULE5
    else $error("Ready module fell back without cause");

  // Flags
  a_flag_sticky: assert property (rst_n_i && !wr_status // see RULE9
    |=> (status & $past(status)) == $past(status))
    else $error("Flag dropped without a clear");

  a_set_wins: assert property (rst_n_i |=> (status & $past(set_vec)) == $past(set_vec)) // see RULE9
    else $error("Event lost against a clear");

  a_w1c_ready: assert property (wr_status && pwdata_i[READY_BIT] && !ready_evt // see RULE9
    |=> !status[READY_BIT])
    else $error("Ready flag not cleared by write");

  a_cond_latch: assert property (|cond_i // see RULE9
    |=> (status[STAT_W-1:COND_LSB] & $past(cond_i)) == $past(cond_i))
    else $error("Condition not latched");

  // Interrupt output
  a_irq_source: assert property (rst_n_i |=> irq_o == $past(pend)) // see RULE1
    else $error("Interrupt does not follow pending flags");

  a_all_masked: assert property (mask == 5'h1f |=> !irq_o) // see RULE10
    else $error("Interrupt with every flag masked");

  a_no_flag_quiet: assert property (next_status == '0 |=> !irq_o) // see RULE9
    else $error("Interrupt with no flag set");

  a_irq_ready: assert property (ready_evt && !mask[READY_BIT] |=> irq_o) // see RULE6
    else $error("Ready event gave no interrupt");

  a_present_low: assert property (!module_present_n_o)
    else $error("Module present pin not low");

  c_ready: cover property ($fell(not_ready));
  c_refused: cover property (done && pslverr_o);
  c_wake_after_pd: cover property ($fell(pdown) ##[1:20] !not_ready);
  c_set_clear_same: cover property (wr_status && |(clr_vec & set_vec));
  c_mask_resume: cover property (wr_mask && !pwdata_i[READY_BIT] ##2 irq_o);

endmodule : mmc_top

// [tb/mmc_host_pins.sv]
// Host board side of the control pins, registered like a board driver
module mmc_host_pins (
  input wire logic sys_clk_i,
  input wire logic sel_i,
  input wire logic lp_i,
  output logic module_select_n_o,
  output logic low_power_pin_o,
  output logic module_reset_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Select is driven low to address the module; reset pin kept released
  always_ff @(posedge sys_clk_i) begin
    module_select_n_o <= !sel_i;
    low_power_pin_o <= lp_i;
    module_reset_n_o <= 1'b1;
  end
endmodule : mmc_host_pins

// [tb/mmc_top_test.sv]
module mmc_top_test import mmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } mmc_row_t;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic sel = 1'b1, lp = 1'b0, er, ss_n, mr_n, lpp;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0000_0000, rd, prd;
  logic [3:0] cond = 4'h0;
  logic prdy, perr, srq_n, irq, act, lpo, prs_n;
  int err_total = 0, n_compared = 0;
  mmc_row_t rows[9] = '{
    '{1'b0, OFS_STATUS, 32'h0000_0000, 32'h0000_0001, 1'b0},
    '{1'b0, OFS_MASK, 32'h0000_0000, 32'h0000_001f, 1'b0},
    '{1'b0, OFS_CTRL, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000, 1'b1},
    '{1'b1, OFS_STATUS, 32'h0000_0001, 32'h0000_0000, 1'b0},
    '{1'b0, OFS_STATUS, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b1, OFS_CTRL, 32'h0000_0001, 32'h0000_0000, 1'b0},
    '{1'b0, OFS_CTRL, 32'h0000_0000, 32'h0000_0001, 1'b0},
    '{1'b0, OFS_STATE, 32'h0000_0000, 32'h0000_000b, 1'b0}};
  always #12.5 clk = !clk;
  mmc_host_pins HOST (.sys_clk_i(clk), .sel_i(sel), .lp_i(lp), .module_select_n_o(ss_n),
    .low_power_pin_o(lpp), .module_reset_n_o(mr_n));
  mmc_top #(.WAKE_CYC(20)) DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .module_select_n_i(ss_n), .module_reset_n_i(mr_n),
    .low_power_pin_i(lpp), .cond_i(cond), .service_request_n_o(srq_n), .irq_o(irq),
    .bus_active_o(act), .low_power_o(lpo), .module_present_n_o(prs_n));
  // Request held until pready is seen at a rising edge; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk) pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    {psel, pen} <= 2'b00;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Whole run is well under 1000 cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(rd, rows[i].x);
      chk(32'(er), 32'(rows[i].e));
    end
    chk(32'(lpo), 32'h0000_0001);
    // Leaving power-down: ready flag returns after the shortened wake count
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk(32'(lpo), 32'h0000_0000);
    repeat (24) @(posedge clk);
    apb(1'b0, OFS_STATE, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    apb(1'b1, OFS_MASK, 32'h0000_001e);
    repeat (2) @(posedge clk);
    chk(32'({irq, srq_n}), 32'h0000_0002);
    apb(1'b1, OFS_MASK, 32'h0000_001f);
    repeat (2) @(posedge clk);
    chk(32'({irq, srq_n}), 32'h0000_0001);
    apb(1'b1, OFS_MASK, 32'h0000_001e);
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk(32'({irq, srq_n}), 32'h0000_0001);
    // A one-cycle condition pulse must stay latched
    cond <= 4'h2;
    @(posedge clk) cond <= 4'h0;
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    sel <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(act), 32'h0000_0000);
    apb(1'b0, OFS_MASK, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    sel <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b0, OFS_MASK, 32'h0000_0000);
    chk(rd, 32'h0000_001e);
    chk(32'(act), 32'h0000_0001);
    chk(32'(prs_n), 32'h0000_0000);
    // Low power pin forces low power without touching readiness
    lp <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(lpo), 32'h0000_0001);
    apb(1'b0, OFS_STATE, 32'h0000_0000);
    chk(rd, 32'h0000_000e);
    lp <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(lpo), 32'h0000_0000);
    final_report();
  end
endmodule : mmc_top_test
